// ===== pmsb_consts.svh
/*
 * Address map, field positions and fixed values of the scratch and buck
 * register slice.
 * Assumes inclusion by bare name from the design modules and the testbench.
 */
`ifndef PMSB_CONSTS_SVH
`define PMSB_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses, functional page
// ----------------------------------------------------------------------
`define PMSB_ADDR_SCRATCH_A  8'h1C
`define PMSB_ADDR_SCRATCH_B  8'h1D
`define PMSB_ADDR_SCRATCH_C  8'h1E
`define PMSB_ADDR_SCRATCH_D  8'h1F
`define PMSB_ADDR_BUCK_BASE  8'h20
`define PMSB_BUCK_STRIDE     8'h03
`define PMSB_OFS_VOLT        8'h00
`define PMSB_OFS_MODE        8'h01
`define PMSB_OFS_CONF        8'h02

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMSB_VOLT_MSB        4
`define PMSB_MODE_MSB        3
`define PMSB_PHASE_MSB       5
`define PMSB_PHASE_LSB       4
`define PMSB_FREQ_MSB        3
`define PMSB_FREQ_LSB        2
`define PMSB_ILIM_BIT        0

// ----------------------------------------------------------------------
// Reset value of the scratch bank and current limits in mA
// ----------------------------------------------------------------------
`define PMSB_SCRATCH_RST     8'h00
`define PMSB_ILIM12_HI_MA    12'd2750
`define PMSB_ILIM12_LO_MA    12'd2000
`define PMSB_ILIM3_HI_MA     12'd3000
`define PMSB_ILIM3_LO_MA     12'd2250

`endif

// ===== pmsb_pkg.sv
/*
 * Types shared by the scratch and buck register slice.
 * Assumes nothing beyond the constants header.
 */
package pmsb_pkg;

   // Sequencer-supplied defaults and live voltage and mode codes
   typedef struct packed {
      logic [4:0] volt;   // Output voltage code
      logic [3:0] mode;   // Switching mode code
   } pmsb_seq_t;

   // Configuration fields of one buck
   typedef struct packed {
      logic [1:0] phase;  // Switching clock phase
      logic [1:0] freq;   // Switching frequency
      logic       ilim;   // Current limit select, 1 is the lower limit
   } pmsb_conf_t;

endpackage

// ===== pmsb_scratch.sv
/*
 * Battery-backed scratch bank: a parameterised set of byte registers.
 * Assumes its clear input is already synchronised to clk_sys and that
 * it lives in the always-on domain, so the main reset never reaches it.
 */
`timescale 1ns/1ps
`include "pmsb_consts.svh"

module pmsb_scratch #(
   parameter int NUM   = 4,
   parameter int WIDTH = 8
) (
   input  wire logic                        clk_sys,
   input  wire logic                        ce,
   input  wire logic                        coin_por_n,
   input  wire logic [NUM-1:0]              wr_en,
   input  wire logic [WIDTH-1:0]            wdata,
   output logic      [NUM-1:0][WIDTH-1:0]   mem_q
);

   // ----------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------
   if (NUM < 1 || WIDTH != 8) begin : g_bad_param
      $error("pmsb_scratch: unsupported NUM or WIDTH");
   end

   // ----------------------------------------------------------------------
   // Storage, one byte per generate slice
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < NUM; i++) begin : g_byte
      logic [WIDTH-1:0] byte_r;   // Stored byte
      // Only the coin-cell reset clears; it wins even with ce low
      always_ff @(posedge clk_sys) begin
         if (!coin_por_n) begin
            byte_r <= `PMSB_SCRATCH_RST;
         end else if (ce && wr_en[i]) begin
            byte_r <= wdata;
         end
      end
      assign mem_q[i] = byte_r;
   end

endmodule

// ===== pmsb_regs.sv
/*
 * Scratch memory and buck regulator control registers of the power chip.
 * Assumes the serial control port presents one register access per cycle
 * on reg_addr with reg_wr or reg_rd strobes in the clk_sys domain, that
 * OTP and sequencer defaults are stable on the clk_sys domain during reset,
 * and that coin_cell_por_n arrives asynchronously.
 */
`timescale 1ns/1ps
`include "pmsb_consts.svh"

module pmsb_regs #(
   parameter int NUM_SCRATCH = 4,
   parameter int NUM_BUCK    = 3
) (
   input  wire logic                                  clk_sys,
   input  wire logic                                  rst_n,
   input  wire logic                                  ce,
   input  wire logic                                  coin_cell_por_n,
   input  wire logic [7:0]                            reg_addr,
   input  wire logic                                  reg_wr,
   input  wire logic                                  reg_rd,
   input  wire logic [7:0]                            reg_wdata,
   output logic      [7:0]                            reg_rdata,
   output logic                                       reg_rvalid,
   input  wire pmsb_pkg::pmsb_seq_t  [NUM_BUCK-1:0]   seq_default,
   input  wire pmsb_pkg::pmsb_conf_t [NUM_BUCK-1:0]   otp_conf,
   output pmsb_pkg::pmsb_seq_t       [NUM_BUCK-1:0]   buck_seq,
   output pmsb_pkg::pmsb_conf_t      [NUM_BUCK-1:0]   buck_conf,
   output logic      [NUM_BUCK-1:0][11:0]             buck_ilim_ma,
   output logic      [NUM_SCRATCH-1:0][7:0]           scratch_mem
);

   // ----------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------
   if (NUM_SCRATCH != 4 || NUM_BUCK != 3) begin : g_bad_param
      $error("pmsb_regs: map is defined for four scratch bytes, three bucks");
   end

   // ----------------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------------
   // Scratch window hit
   function automatic logic scr_hit(input logic [7:0] a);
      scr_hit = (a >= `PMSB_ADDR_SCRATCH_A) && (a <= `PMSB_ADDR_SCRATCH_D);
   endfunction

   // Scratch byte index within the window
   function automatic logic [1:0] scr_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - `PMSB_ADDR_SCRATCH_A;
      scr_idx = d[1:0];
   endfunction

   // Address of one buck register
   function automatic logic [7:0] buck_addr(input int b, input logic [7:0] ofs);
      logic [7:0] base;
      base = `PMSB_ADDR_BUCK_BASE + 8'(b) * `PMSB_BUCK_STRIDE;
      buck_addr = base + ofs;
   endfunction

   // Current limit in mA for a buck and its select bit
   function automatic logic [11:0] ilim_ma(input int b, input logic lo);
      if (b == 2) begin
         ilim_ma = lo ? `PMSB_ILIM3_LO_MA : `PMSB_ILIM3_HI_MA;
      end else begin
         ilim_ma = lo ? `PMSB_ILIM12_LO_MA : `PMSB_ILIM12_HI_MA;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Coin-cell reset synchroniser
   // ----------------------------------------------------------------------
   logic por_s1_r;   // First stage, read only by the second
   logic por_s2_r;   // Synchronised coin-cell reset, active low

   // Runs apart from the main reset so a main reset cannot mask it
   always_ff @(posedge clk_sys) begin
      if (ce) begin
         por_s1_r <= coin_cell_por_n;
         por_s2_r <= por_s1_r;
      end
   end

   // ----------------------------------------------------------------------
   // Scratch bank
   // ----------------------------------------------------------------------
   logic                        scr_sel;   // Access targets scratch window
   logic [1:0]                  scr_i;     // Selected scratch byte
   logic [NUM_SCRATCH-1:0]      scr_we;    // Per-byte write strobe

   assign scr_sel = scr_hit(reg_addr);
   assign scr_i   = scr_idx(reg_addr);

   for (genvar s = 0; s < NUM_SCRATCH; s++) begin : g_scr_we
      // Write only while the main domain is out of reset; the bank also needs ce high and its coin-cell clear released
      assign scr_we[s] = rst_n && reg_wr && scr_sel && (scr_i == 2'(s));
   end

   pmsb_scratch #(
      .NUM   (NUM_SCRATCH),
      .WIDTH (8)
   ) u_scratch (
      .clk_sys    (clk_sys),
      .ce         (ce),
      .coin_por_n (por_s2_r),
      .wr_en      (scr_we),
      .wdata      (reg_wdata),
      .mem_q      (scratch_mem)
   );

   // ----------------------------------------------------------------------
   // Buck registers
   // ----------------------------------------------------------------------
   logic [NUM_BUCK-1:0][7:0] buck_rd;   // Read value, zero unless addressed

   for (genvar b = 0; b < NUM_BUCK; b++) begin : g_buck
      localparam logic [7:0] A_VOLT = buck_addr(b, `PMSB_OFS_VOLT);
      localparam logic [7:0] A_MODE = buck_addr(b, `PMSB_OFS_MODE);
      localparam logic [7:0] A_CONF = buck_addr(b, `PMSB_OFS_CONF);

      pmsb_pkg::pmsb_seq_t  seq_r;    // Voltage and mode codes
      pmsb_pkg::pmsb_conf_t conf_r;   // Phase, frequency, limit
      logic                 we_volt;  // Voltage write strobe
      logic                 we_mode;  // Mode write strobe
      logic                 we_conf;  // Config write strobe

      assign we_volt = reg_wr && (reg_addr == A_VOLT);
      assign we_mode = reg_wr && (reg_addr == A_MODE);
      assign we_conf = reg_wr && (reg_addr == A_CONF);

      // Voltage and mode: reset loads the sequencer defaults
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            seq_r <= seq_default[b];
         end else if (ce) begin
            if (we_volt) begin
               seq_r.volt <= reg_wdata[`PMSB_VOLT_MSB:0];
            end
            if (we_mode) begin
               seq_r.mode <= reg_wdata[`PMSB_MODE_MSB:0];
            end
         end
      end

      // Configuration: reset loads the OTP content, bit 1 is not stored
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            conf_r <= otp_conf[b];
         end else if (ce && we_conf) begin
            conf_r.phase <= reg_wdata[`PMSB_PHASE_MSB:`PMSB_PHASE_LSB];
            conf_r.freq  <= reg_wdata[`PMSB_FREQ_MSB:`PMSB_FREQ_LSB];
            conf_r.ilim  <= reg_wdata[`PMSB_ILIM_BIT];
         end
      end

      // Live outputs to the regulator
      assign buck_seq[b]     = seq_r;
      assign buck_conf[b]    = conf_r;
      assign buck_ilim_ma[b] = ilim_ma(b, conf_r.ilim);

      // Read value with reserved bits forced to zero
      assign buck_rd[b] =
         (reg_addr == A_VOLT) ? {3'h0, seq_r.volt} :
         (reg_addr == A_MODE) ? {4'h0, seq_r.mode} :
         (reg_addr == A_CONF) ? {2'h0, conf_r.phase, conf_r.freq, 1'b0, conf_r.ilim} :
         8'h00;
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   logic [7:0] scr_rd;    // Scratch read value
   logic [7:0] rd_mux;    // Combined read value, zero when unmapped
   logic [7:0] rdata_r;   // Registered read data
   logic       rvalid_r;  // Read data valid pulse

   assign scr_rd = scr_sel ? scratch_mem[scr_i] : 8'h00;
   assign rd_mux = scr_rd | buck_rd[0] | buck_rd[1] | buck_rd[2];

   // Capture on the read strobe, answer the next cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else if (ce) begin
         rvalid_r <= reg_rd;
         if (reg_rd) begin
            rdata_r <= rd_mux;
         end
      end
   end

   assign reg_rdata  = rdata_r;
   assign reg_rvalid = rvalid_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   // Coin-cell reset clears the bank on the next edge
   a_scratch_por_clear: assert property (@(posedge clk_sys)
      !por_s2_r |=> (scratch_mem == '0))
      else $error("scratch bank not cleared by coin-cell reset");

   // Main reset alone leaves the bank untouched
   a_scratch_main_keep: assert property (@(posedge clk_sys)
      (!rst_n && por_s2_r) |=> (scratch_mem == $past(scratch_mem)))
      else $error("scratch bank changed under main reset");

   // Write to the second scratch byte lands there
   a_scratch_b_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && por_s2_r && reg_wr && reg_addr == `PMSB_ADDR_SCRATCH_B)
      |=> (scratch_mem[1] == $past(reg_wdata)))
      else $error("second scratch byte did not take the write");

   // Voltage write of buck 1 shows on its output
   a_buck_volt_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == `PMSB_ADDR_BUCK_BASE)
      |=> (buck_seq[0].volt == $past(reg_wdata[4:0])))
      else $error("buck 1 voltage code not updated");

   // Mode write of buck 2 shows on its output and leaves voltage alone
   a_buck_mode_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h24)
      |=> (buck_seq[1].mode == $past(reg_wdata[3:0]))
          && (buck_seq[1].volt == $past(buck_seq[1].volt)))
      else $error("buck 2 mode code not updated");

   // Config write of buck 3 splits phase and frequency correctly
   a_conf_fields_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h28)
      |=> (buck_conf[2].phase == $past(reg_wdata[5:4]))
          && (buck_conf[2].freq == $past(reg_wdata[3:2])))
      else $error("buck 3 phase or frequency field wrong");

   // Limit select maps to the documented currents
   a_ilim_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h22 && reg_wdata[0])
      |=> (buck_ilim_ma[0] == 12'd2000) && (buck_ilim_ma[2] ==
          (buck_conf[2].ilim ? 12'd2250 : 12'd3000)))
      else $error("current limit mapping wrong");

   // Reset loads OTP config and sequencer defaults
   a_reset_defaults: assert property (@(posedge clk_sys)
      !rst_n |=> (buck_conf == $past(otp_conf)) && (buck_seq == $past(seq_default)))
      else $error("reset defaults not loaded");

   // Reserved bits of a config readback are zero
   a_conf_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == 8'h25)
      |=> reg_rvalid && (reg_rdata[7:6] == 2'h0) && (reg_rdata[1] == 1'b0))
      else $error("reserved config bits read nonzero");

   // Read of the second scratch byte returns its content
   a_scratch_b_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == `PMSB_ADDR_SCRATCH_B)
      |=> reg_rdata == $past(scratch_mem[1]))
      else $error("second scratch byte read wrong");

   // Reads outside the map return zero
   a_unmapped_rd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_rd && (reg_addr < `PMSB_ADDR_SCRATCH_A || reg_addr > 8'h28))
      |=> reg_rvalid && (reg_rdata == 8'h00))
      else $error("unmapped address read nonzero");

   // Read valid only follows a read strobe
   a_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && !reg_rd)
      |=> !reg_rvalid)
      else $error("read valid without a read strobe");

   // Clock enable low freezes the scratch bank while the coin-cell reset is released
   a_scratch_ce_hold: assert property (@(posedge clk_sys)
      (!ce && por_s2_r)
      |=> (scratch_mem == $past(scratch_mem)))
      else $error("scratch bank changed with clock enable low");

   // Clock enable low freezes the buck registers outside reset
   a_buck_ce_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !ce
      |=> (buck_seq == $past(buck_seq)) && (buck_conf == $past(buck_conf)))
      else $error("buck registers changed with clock enable low");

   // Write to the first scratch byte lands there
   a_scratch_a_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && por_s2_r && reg_wr && reg_addr == `PMSB_ADDR_SCRATCH_A)
      |=> (scratch_mem[0] == $past(reg_wdata)))
      else $error("first scratch byte did not take the write");

   // Write to the last scratch byte lands there
   a_scratch_d_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && por_s2_r && reg_wr && reg_addr == `PMSB_ADDR_SCRATCH_D)
      |=> (scratch_mem[3] == $past(reg_wdata)))
      else $error("last scratch byte did not take the write");

   // Reserved bits of a voltage readback are zero
   a_volt_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == 8'h23)
      |=> reg_rvalid && (reg_rdata[7:5] == 3'h0))
      else $error("reserved voltage bits read nonzero");

   // Reserved bits of a mode readback are zero
   a_mode_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == 8'h27)
      |=> reg_rvalid && (reg_rdata[7:4] == 4'h0))
      else $error("reserved mode bits read nonzero");

   // Voltage read of buck 3 returns its live code
   a_buck_volt_rd: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == 8'h26)
      |=> (reg_rdata[4:0] == $past(buck_seq[2].volt)))
      else $error("buck 3 voltage read wrong");

   // Config write of buck 1 splits phase and frequency correctly
   a_conf1_fields_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h22)
      |=> (buck_conf[0].phase == $past(reg_wdata[5:4])) && (buck_conf[0].freq == $past(reg_wdata[3:2])))
      else $error("buck 1 phase or frequency field wrong");

   // Buck 3 limit select maps to its own currents
   a_ilim3_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h28)
      |=> (buck_ilim_ma[2] == ($past(reg_wdata[0]) ? 12'd2250 : 12'd3000)))
      else $error("buck 3 current limit mapping wrong");

   // Buck 2 limit select maps to the shared currents
   a_ilim2_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h25)
      |=> (buck_ilim_ma[1] == ($past(reg_wdata[0]) ? 12'd2000 : 12'd2750)))
      else $error("buck 2 current limit mapping wrong");

   // Two low samples of the coin-cell pin reach the bank clear
   a_por_sync_delay: assert property (@(posedge clk_sys)
      (ce && !coin_cell_por_n) ##1 (ce && !coin_cell_por_n)
      |=> !por_s2_r)
      else $error("coin-cell reset not passed through the synchroniser");

   // Voltage write of buck 2 leaves its mode code alone
   a_volt_keeps_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h23)
      |=> (buck_seq[1].volt == $past(reg_wdata[4:0])) && (buck_seq[1].mode == $past(buck_seq[1].mode)))
      else $error("buck 2 voltage write disturbed the mode code");

endmodule

// ===== test_pmsb_regs.sv
/*
 * Self-checking testbench for the scratch and buck register slice.
 * Assumes the design files and the constants header are compiled first;
 * a byte-wide model of the register map is compared at every result.
 */
`timescale 1ns/1ps
`include "pmsb_consts.svh"

module test_pmsb_regs;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic                               clk_sys;          // 50 MHz clock
   logic                               rst_n;            // Main reset
   logic                               ce;               // Clock enable
   logic                               coin_cell_por_n;  // Coin-cell reset
   logic [7:0]                         reg_addr;         // Access address
   logic                               reg_wr;           // Write strobe
   logic                               reg_rd;           // Read strobe
   logic [7:0]                         reg_wdata;        // Write data
   logic [7:0]                         reg_rdata;        // Read data
   logic                               reg_rvalid;       // Read data valid
   pmsb_pkg::pmsb_seq_t  [2:0]         seq_default;      // Sequencer defaults
   pmsb_pkg::pmsb_conf_t [2:0]         otp_conf;         // OTP defaults
   pmsb_pkg::pmsb_seq_t  [2:0]         buck_seq;         // Live codes
   pmsb_pkg::pmsb_conf_t [2:0]         buck_conf;        // Live config
   logic [2:0][11:0]                   buck_ilim_ma;     // Decoded limit
   logic [3:0][7:0]                    scratch_mem;      // Scratch bytes
   logic [7:0]                         mdl [0:255];      // Register model
   integer                             n_fail;           // Mismatch count
   integer                             checked;          // Compare count
   integer                             seed;             // Random seed
   integer                             cycles;           // Timeout counter
   integer                             i;                // Loop index

   // ---------------------------------------------------------------
   // Design under test
   // ---------------------------------------------------------------
   pmsb_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .coin_cell_por_n(coin_cell_por_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .seq_default(seq_default), .otp_conf(otp_conf),
      .buck_seq(buck_seq), .buck_conf(buck_conf), .buck_ilim_ma(buck_ilim_ma),
      .scratch_mem(scratch_mem));

   // Clock and hang guard
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Model helpers
   // ---------------------------------------------------------------
   // Writable bits of each address, zero where unmapped
   function automatic logic [7:0] wmask(input logic [7:0] a);
      if (a >= 8'h1C && a <= 8'h1F) return 8'hFF;
      if (a >= 8'h20 && a <= 8'h28) begin
         case ((a - 8'h20) % 3)
            0: return 8'h1F;
            1: return 8'h0F;
            default: return 8'h3D;
         endcase
      end
      return 8'h00;
   endfunction

   // Load buck defaults into the model
   task automatic load_defaults();
      for (int n = 0; n < 3; n++) begin
         mdl[8'h20 + 3*n] = {3'h0, seq_default[n].volt};
         mdl[8'h21 + 3*n] = {4'h0, seq_default[n].mode};
         mdl[8'h22 + 3*n] = {2'h0, otp_conf[n].phase, otp_conf[n].freq, 1'b0,
                             otp_conf[n].ilim};
      end
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Compare every register output with the model
   task automatic check_outs();
      logic [7:0] c;
      for (int k = 0; k < 4; k++) chk(scratch_mem[k], mdl[8'h1C + k]);
      for (int n = 0; n < 3; n++) begin
         c = mdl[8'h22 + 3*n];
         chk(buck_seq[n], {mdl[8'h20 + 3*n][4:0], mdl[8'h21 + 3*n][3:0]});
         chk(buck_conf[n], {c[5:4], c[3:2], c[0]});
         if (n < 2) chk(buck_ilim_ma[n], c[0] ? 12'd2000 : 12'd2750);
         else chk(buck_ilim_ma[n], c[0] ? 12'd2250 : 12'd3000);
      end
   endtask

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
      if (ce === 1'b1) mdl[a] = d & wmask(a);
      check_outs();
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rvalid, 1'b1);
      chk(reg_rdata, mdl[a]);
   endtask

   // Apply main reset with fresh random defaults
   task automatic main_reset(input int len);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      {seq_default, otp_conf} <= 42'({$random(seed), $random(seed)});
      repeat (len) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      load_defaults();
   endtask

   task automatic report_and_stop();
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      coin_cell_por_n = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      seed = 40959;
      n_fail = 0;
      checked = 0;
      cycles = 0;
      for (i = 0; i < 256; i++) mdl[i] = 8'h00;
      {seq_default, otp_conf} = 42'({$random(seed), $random(seed)});
      // Coin-cell reset released first, main reset held 12 cycles
      repeat (5) @(posedge clk_sys);
      coin_cell_por_n <= 1'b1;
      repeat (7) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      load_defaults();
      check_outs();
      rd(`PMSB_ADDR_SCRATCH_B);
      // All ones to every address from 0x18 to 0x2B, mapped or not, then read back
      for (i = 8'h18; i < 8'h2C; i++) wr(i[7:0], 8'hFF);
      for (i = 8'h18; i < 8'h2C; i++) rd(i[7:0]);
      // Random traffic over the map and its neighbours
      for (i = 0; i < 300; i++) begin
         if ($random(seed) & 1) wr(8'h18 + 8'($unsigned($random(seed)) % 20), 8'($random(seed)));
         else rd(8'h18 + 8'($unsigned($random(seed)) % 20));
      end
      // Clock enable low freezes writes
      ce <= 1'b0;
      wr(`PMSB_ADDR_SCRATCH_C, 8'hA5);
      wr(`PMSB_ADDR_BUCK_BASE, 8'h0A);
      @(posedge clk_sys);
      ce <= 1'b1;
      // Main reset keeps scratch, reloads buck defaults
      for (i = 0; i < 4; i++) wr(8'h1C + i[7:0], 8'h5A ^ i[7:0]);
      main_reset(3);
      check_outs();
      for (i = 8'h1C; i < 8'h29; i++) rd(i[7:0]);
      // Coin-cell reset clears the scratch bank
      @(posedge clk_sys);
      coin_cell_por_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      coin_cell_por_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      for (i = 0; i < 4; i++) mdl[8'h1C + i] = `PMSB_SCRATCH_RST;
      check_outs();
      rd(`PMSB_ADDR_SCRATCH_D);
      report_and_stop();
   end
endmodule
